/* rtl/skip_and_stack_sequencer.sv */
/*
  Program sequencer of a small 4-bit core: program counter with page and
  in-page fields, return-address stack, data memory pointer and skip
  nullification with fixed instruction timing, except that nullified lookups and returns take one cycle.
  Assumes one clock per instruction cycle; the decoder presents each new
  instruction's operation, cycle count and targets with op_valid.
*/
`timescale 1ns/10ps
module skip_and_stack_sequencer
  import seq_pkg::*;
(
  input  wire logic              clock,         // Instruction clock
  input  wire logic              reset_n,       // Async reset, active low
  input  wire logic              op_valid,      // New instruction starts
  input  wire seq_op_t           op_kind,       // Sequencing operation
  input  wire logic [CYC_W-1:0]  op_cycles,     // Normal cycle count
  input  wire logic              skip_request,  // Condition taken
  input  wire logic [PAGE_W-1:0] target_page,   // Branch page
  input  wire logic [ADDR_W-1:0] target_addr,   // Branch in-page address
  input  wire logic              x_load,        // Load upper index
  input  wire logic [X_W-1:0]    x_value,       // Upper index value
  input  wire logic              y_load,        // Load lower index
  input  wire logic [Y_W-1:0]    y_value,       // Lower index value
  output logic [PC_W-1:0]        program_counter,       // Fetch address
  output logic [PAGE_W-1:0]      page_select_bits,      // Page field
  output logic [ADDR_W-1:0]      in_page_address_bits,  // In-page field
  output logic [SP_W-1:0]        stack_level_pointer,   // Stack level
  output logic [MP_W-1:0]        memory_pointer,        // Data pointer
  output logic                   nullify,       // Current instr. suppressed
  output logic                   busy,          // Later cycle of instr.
  output logic                   skip_armed     // Next instr. nullified
);
  typedef struct packed {
    logic [PC_W-1:0]  pc;
    logic [X_W-1:0]   x;
    logic [Y_W-1:0]   y;
    phase_t           phase;
    logic [CYC_W-1:0] cycles_left;
    logic             null_now;
    logic             skip;
    logic             in_table;
  } seq_state_t;

  seq_state_t state;
  seq_state_t next_state;
  stack_if    stk ();
  logic       accept;
  logic       short_op;
  logic [CYC_W-1:0] cyc;
  logic [PC_W-1:0]  pc_inc;

  return_address_stack u_stack (
    .clock   (clock),
    .reset_n (reset_n),
    .port    (stk.stk)
  );

  // Start is taken only between instructions
  assign accept   = op_valid && (state.phase == PH_FETCH);
  assign short_op = (op_kind == OP_TABLE_LOOKUP_CALL)
                 || (op_kind == OP_RETURN_PLAIN)
                 || (op_kind == OP_RETURN_SKIP);
  assign pc_inc   = state.pc + PC_STEP;

  // Next-state logic
  always_comb begin
    next_state    = state;
    stk.push      = 1'b0;
    stk.pop       = 1'b0;
    stk.push_data = pc_inc;
    cyc           = (op_cycles == '0) ? ONE_CYCLE : op_cycles;
    if (x_load) begin
      next_state.x = x_value;
    end
    if (y_load) begin
      next_state.y = y_value;
    end
    unique case (state.phase)
      PH_FETCH: begin
        if (accept) begin
          next_state.null_now = state.skip;
          if (state.skip) begin
            next_state.skip = 1'b0;
            next_state.pc   = pc_inc;
            if (short_op) begin
              cyc = NULL_CYCLES;
            end
          end else begin
            next_state.skip = skip_request || (op_kind == OP_RETURN_SKIP);
            case (op_kind)
              OP_BRANCH_IN_PAGE: next_state.pc = {state.pc[PC_W-1:ADDR_W],
                                                  target_addr};
              OP_BRANCH_LONG:    next_state.pc = {target_page, target_addr};
              OP_CALL: begin
                stk.push      = 1'b1;
                next_state.pc = {target_page, target_addr};
              end
              OP_TABLE_LOOKUP_CALL: begin
                stk.push            = 1'b1;
                next_state.pc       = {target_page, target_addr};
                next_state.in_table = (cyc != ONE_CYCLE);
              end
              OP_RETURN_PLAIN, OP_RETURN_SKIP: begin
                stk.pop       = 1'b1;
                next_state.pc = stk.top_data;
              end
              default:           next_state.pc = pc_inc;
            endcase
          end
          if (cyc != ONE_CYCLE) begin
            next_state.phase       = PH_HOLD;
            next_state.cycles_left = cyc - ONE_CYCLE;
          end
        end
      end
      PH_HOLD: begin
        next_state.cycles_left = state.cycles_left - ONE_CYCLE;
        if (state.cycles_left == ONE_CYCLE) begin
          next_state.phase = PH_FETCH;
          // Lookup ends by returning to the caller
          if (state.in_table) begin
            stk.pop             = 1'b1;
            next_state.pc       = stk.top_data;
            next_state.in_table = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{pc: PC_RESET, x: X_RESET, y: Y_RESET, phase: PH_FETCH,
                 cycles_left: '0, null_now: 1'b0, skip: 1'b0,
                 in_table: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from state registers
  assign program_counter      = state.pc;
  assign page_select_bits     = state.pc[PC_W-1:ADDR_W];
  assign in_page_address_bits = state.pc[ADDR_W-1:0];
  assign stack_level_pointer  = stk.level;
  assign memory_pointer       = {state.x, state.y};
  assign nullify              = state.null_now;
  assign busy                 = (state.phase == PH_HOLD);
  assign skip_armed           = state.skip;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_null_start;
    accept && skip_armed;
  endsequence

  sequence s_three_cycle_hold;
    busy [*2] ##1 !busy;
  endsequence

  AST_NULL_STEP_ONE: assert property (
    s_null_start |=> nullify && program_counter == $past(program_counter)
      + PC_STEP && !skip_armed)
    else $error("nullified instruction did not step pc by one");

  AST_NULL_KEEPS_TIME: assert property (
    s_null_start ##0 (!short_op && op_cycles == 2'h3) |=> s_three_cycle_hold)
    else $error("nullified instruction changed cycle count");

  AST_NULL_SHORT: assert property (
    s_null_start ##0 short_op |=> !busy
      && stack_level_pointer == $past(stack_level_pointer))
    else $error("nullified lookup or return not one cycle");

  AST_LONG_BRANCH: assert property (
    accept && !skip_armed && op_kind == OP_BRANCH_LONG
      |=> program_counter == {$past(target_page), $past(target_addr)})
    else $error("long branch loaded wrong address");

  AST_PAGE_KEPT: assert property (
    accept && !skip_armed && op_kind == OP_BRANCH_IN_PAGE
      |=> page_select_bits == $past(page_select_bits)
      && in_page_address_bits == $past(target_addr))
    else $error("in-page branch disturbed page field");

  AST_CALL_RETURN: assert property (
    accept && !skip_armed && op_kind == OP_CALL && op_cycles == 2'h1
      ##1 accept && !skip_armed && op_kind == OP_RETURN_PLAIN
      && op_cycles == 2'h1
      |=> program_counter == $past(program_counter, 2) + PC_STEP)
    else $error("return did not resume after call");

  AST_POINTER_LOAD: assert property (
    x_load && y_load |=> memory_pointer == {$past(x_value), $past(y_value)})
    else $error("memory pointer not formed from indexes");

  AST_PLAIN_STEP: assert property (
    accept && !skip_armed && op_kind == OP_NEXT
      |=> program_counter == $past(program_counter) + PC_STEP)
    else $error("pc did not increment after fetch");
endmodule : skip_and_stack_sequencer

/* rtl/seq_pkg.sv */
/*
  Shared constants and types for the program sequencer: counter widths,
  stack geometry, memory pointer layout, sequencing operation codes.
  Assumes a single instruction clock driving every sequencer register.
*/
package seq_pkg;
  localparam int PC_W        = 10;
  localparam int PAGE_W      = 3;
  localparam int ADDR_W      = 7;
  localparam int SP_W        = 2;
  localparam int STACK_DEPTH = 4;
  localparam int X_W         = 2;
  localparam int Y_W         = 4;
  localparam int MP_W        = 6;
  localparam int CYC_W       = 2;

  // Reset and step values
  localparam logic [PC_W-1:0]  PC_RESET    = 10'h000;
  localparam logic [PC_W-1:0]  PC_STEP     = 10'h001;
  localparam logic [SP_W-1:0]  SP_RESET    = 2'h3;
  localparam logic [SP_W-1:0]  SP_STEP     = 2'h1;
  localparam logic [X_W-1:0]   X_RESET     = 2'h0;
  localparam logic [Y_W-1:0]   Y_RESET     = 4'h0;
  localparam logic [CYC_W-1:0] ONE_CYCLE   = 2'h1;
  localparam logic [CYC_W-1:0] NULL_CYCLES = 2'h1;

  // Sequencing operation of the instruction being started
  typedef enum logic [2:0] {
    OP_NEXT              = 3'h0,
    OP_BRANCH_IN_PAGE    = 3'h1,
    OP_BRANCH_LONG       = 3'h2,
    OP_CALL              = 3'h3,
    OP_TABLE_LOOKUP_CALL = 3'h4,
    OP_RETURN_PLAIN      = 3'h5,
    OP_RETURN_SKIP       = 3'h6
  } seq_op_t;

  // Instruction phase, one-hot
  typedef enum logic [1:0] {
    PH_FETCH = 2'h1,
    PH_HOLD  = 2'h2
  } phase_t;
endpackage : seq_pkg

/* rtl/stack_if.sv */
/*
  Connection between the sequencer and its return-address stack.
  Assumes push and pop are never raised in the same cycle.
*/
`timescale 1ns/10ps
interface stack_if;
  import seq_pkg::*;
  logic              push;
  logic              pop;
  logic [PC_W-1:0]   push_data;
  logic [PC_W-1:0]   top_data;
  logic [SP_W-1:0]   level;

  modport seq (output push, pop, push_data, input top_data, level);
  modport stk (input push, pop, push_data, output top_data, level);
endinterface : stack_if

/* rtl/return_address_stack.sv */
/*
  Four-level return-address stack with its two-bit level pointer.
  Assumes the sequencer never pushes and pops in one cycle.
*/
`timescale 1ns/10ps
module return_address_stack
  import seq_pkg::*;
(
  input wire logic clock,    // Instruction clock
  input wire logic reset_n,  // Asynchronous reset, active low
  stack_if.stk     port      // Push, pop and top of stack
);
  typedef struct packed {
    logic [SP_W-1:0]                   level;
    logic [STACK_DEPTH-1:0][PC_W-1:0]  entry;
  } stack_state_t;

  stack_state_t state;
  stack_state_t next_state;
  logic [SP_W-1:0] up_level;

  // push writes above, pop steps down
  always_comb begin
    next_state = state;
    up_level   = state.level + SP_STEP;
    if (port.push) begin
      next_state.level           = up_level;
      next_state.entry[up_level] = port.push_data;
    end else if (port.pop) begin
      next_state.level = state.level - SP_STEP;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{level: SP_RESET, entry: '0};
    end else begin
      state <= next_state;
    end
  end

  // Top of stack and level
  assign port.top_data = state.entry[state.level];
  assign port.level    = state.level;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_PUSH_STORES: assert property (
    port.push |=> port.top_data == $past(port.push_data)
      && port.level == $past(port.level) + SP_STEP)
    else $error("push did not store return address");

  AST_POP_LEVEL: assert property (
    port.pop && !port.push |=> port.level == $past(port.level) - SP_STEP)
    else $error("pop did not lower stack level");
endmodule : return_address_stack

/* test/tb_top.sv */
/*
  Self-checking bench for the program sequencer. It covers fetch stepping,
  the page and in-page branch fields, calls and returns, the index
  registers, and skip nullification with its cycle counts.
  Assumes seq_pkg and the sequencer top are compiled before this file.
*/
`timescale 1ns/10ps
module tb_top;
  import seq_pkg::*;
  logic              clock, reset_n, op_valid, skip_request;
  logic              x_load, y_load, nullify, busy, skip_armed;
  seq_op_t           op_kind;
  logic [CYC_W-1:0]  op_cycles;
  logic [PAGE_W-1:0] target_page, page_select_bits;
  logic [ADDR_W-1:0] target_addr, in_page_address_bits;
  logic [X_W-1:0]    x_value;
  logic [Y_W-1:0]    y_value;
  logic [PC_W-1:0]   program_counter, pc_e;
  logic [SP_W-1:0]   stack_level_pointer;
  logic [MP_W-1:0]   memory_pointer;
  int                fails, total_checks, cyc, n;
  seq_op_t           shorts [3];

  skip_and_stack_sequencer i_skip_and_stack_sequencer (
    .clock(clock), .reset_n(reset_n), .op_valid(op_valid),
    .op_kind(op_kind), .op_cycles(op_cycles), .skip_request(skip_request),
    .target_page(target_page), .target_addr(target_addr),
    .x_load(x_load), .x_value(x_value), .y_load(y_load),
    .y_value(y_value), .program_counter(program_counter),
    .page_select_bits(page_select_bits),
    .in_page_address_bits(in_page_address_bits),
    .stack_level_pointer(stack_level_pointer),
    .memory_pointer(memory_pointer), .nullify(nullify), .busy(busy),
    .skip_armed(skip_armed));

  // Clock source, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Cut a hung run short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One instruction start, inputs moved on rising edges only
  task automatic issue(input seq_op_t k, input logic [1:0] c,
                       input logic s, input logic [9:0] t);
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind <= k;
    op_cycles <= c;
    skip_request <= s;
    {target_page, target_addr} <= t;
    @(posedge clock);
    op_valid <= 1'b0;
    skip_request <= 1'b0;
    #1;
  endtask : issue

  task automatic count_busy();
    n = 0;
    while (busy !== 1'b0 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : count_busy

  task automatic load_idx(input logic xl, input logic yl,
                          input logic [1:0] xv, input logic [3:0] yv);
    @(posedge clock);
    x_load <= xl;
    y_load <= yl;
    x_value <= xv;
    y_value <= yv;
    @(posedge clock);
    x_load <= 1'b0;
    y_load <= 1'b0;
    @(posedge clock);
    #1;
  endtask : load_idx

  task automatic t_reset_and_step();
    chk(program_counter, 10'h000);
    chk(10'(stack_level_pointer), 10'h003);
    chk(10'({nullify, busy, skip_armed}), 10'h000);
    issue(OP_NEXT, 2'h1, 1'b0, 10'h000);
    chk(program_counter, 10'h001);
    issue(OP_NEXT, 2'h1, 1'b0, 10'h000);
    chk(program_counter, 10'h002);
  endtask : t_reset_and_step

  task automatic t_branch();
    issue(OP_BRANCH_LONG, 2'h1, 1'b0, 10'h292);
    chk(program_counter, 10'h292);
    chk(10'(page_select_bits), 10'h005);
    chk(10'(in_page_address_bits), 10'h012);
    issue(OP_BRANCH_IN_PAGE, 2'h1, 1'b0, 10'h040);
    chk(program_counter, 10'h2c0);
  endtask : t_branch

  task automatic t_index();
    chk(10'(memory_pointer), 10'h000);
    load_idx(1'b1, 1'b1, 2'h2, 4'h9);
    chk(10'(memory_pointer), 10'h029);
    load_idx(1'b0, 1'b1, 2'h1, 4'hf);
    chk(10'(memory_pointer), 10'h02f);
  endtask : t_index

  task automatic t_call_return();
    issue(OP_CALL, 2'h1, 1'b0, 10'h085);
    chk(program_counter, 10'h085);
    chk(10'(stack_level_pointer), 10'h000);
    issue(OP_CALL, 2'h1, 1'b0, 10'h103);
    chk(10'(stack_level_pointer), 10'h001);
    issue(OP_RETURN_PLAIN, 2'h1, 1'b0, 10'h000);
    chk(program_counter, 10'h086);
    issue(OP_RETURN_SKIP, 2'h1, 1'b0, 10'h000);
    chk(program_counter, 10'h2c1);
    chk(10'({stack_level_pointer, skip_armed}), 10'h007);
  endtask : t_call_return

  // Armed skip meets a three-cycle branch
  task automatic t_skip_long();
    issue(OP_BRANCH_LONG, 2'h3, 1'b0, 10'h3ff);
    chk(program_counter, 10'h2c2);
    chk(10'({nullify, skip_armed, busy}), 10'h005);
    count_busy();
    chk(10'(n), 10'h002);
    issue(OP_NEXT, 2'h1, 1'b0, 10'h000);
    chk(program_counter, 10'h2c3);
    chk(10'(nullify), 10'h000);
  endtask : t_skip_long

  // Nullified lookup and returns take one cycle and leave the stack
  task automatic t_skip_short();
    pc_e = 10'h2c3;
    foreach (shorts[i]) begin
      issue(OP_NEXT, 2'h1, 1'b1, 10'h000);
      chk(10'(skip_armed), 10'h001);
      issue(shorts[i], 2'h3, 1'b0, 10'h155);
      pc_e = pc_e + 10'h002;
      chk(program_counter, pc_e);
      chk(10'({nullify, busy, skip_armed}), 10'h004);
      chk(10'(stack_level_pointer), 10'h003);
    end
  endtask : t_skip_short

  // Executed three-cycle lookup runs full length
  task automatic t_table();
    issue(OP_TABLE_LOOKUP_CALL, 2'h3, 1'b0, 10'h190);
    chk(program_counter, 10'h190);
    count_busy();
    chk(10'(n), 10'h002);
    chk(program_counter, pc_e + 10'h001);
    chk(10'(stack_level_pointer), 10'h003);
  endtask : t_table

  // One-cycle call and return accepted on consecutive edges
  task automatic t_back_to_back();
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind <= OP_CALL;
    op_cycles <= 2'h1;
    skip_request <= 1'b0;
    {target_page, target_addr} <= 10'h3a0;
    @(posedge clock);
    op_kind <= OP_RETURN_PLAIN;
    #1;
    chk(program_counter, 10'h3a0);
    chk(10'(stack_level_pointer), 10'h000);
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    chk(program_counter, 10'h2cb);
    chk(10'(stack_level_pointer), 10'h003);
  endtask : t_back_to_back

  // A start offered while busy is ignored
  task automatic t_refused();
    issue(OP_BRANCH_LONG, 2'h3, 1'b0, 10'h100);
    chk(program_counter, 10'h100);
    issue(OP_BRANCH_LONG, 2'h1, 1'b0, 10'h3ff);
    chk(program_counter, 10'h100);
    chk(10'(busy), 10'h000);
  endtask : t_refused

  // Main sequence
  initial begin
    shorts = '{OP_TABLE_LOOKUP_CALL, OP_RETURN_PLAIN, OP_RETURN_SKIP};
    {reset_n, op_valid, skip_request, x_load, y_load} = '0;
    {op_cycles, target_page, target_addr, x_value, y_value} = '0;
    op_kind = OP_NEXT;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    t_reset_and_step();
    t_branch();
    t_index();
    t_call_return();
    t_skip_long();
    t_skip_short();
    t_table();
    t_back_to_back();
    t_refused();
    summarize();
  end
endmodule : tb_top
